// File: hdl/hmsb_consts.svh
// Constants for the hub management status bus transmitter
// Functional notes
// - Drive 10 MHz clock with NRZ data
// - Only the receiving chip drives bus lines
// - Carrier sense is a two-way line
// - Serial data is the repeated stream
// - Append seven status bytes at frame end
// - Status bytes two to seven come from the status registers
// - Every byte goes out LSB first
// - Truncation stops clock at decode byte count
// - Early end appends status byte aligned
// - Held truncation keeps carrier, defers status
// - Late truncate request is ignored
// - By default forward only frames with SFD
// - Filter enable zero forwards all activity
// - Minimum gap is threshold plus one
// - Short gap: carrier on, clock stopped
// - First status byte: address, truncation flag
// - Dummy bits byte-align the status field
`ifndef HMSB_CONSTS_SVH
`define HMSB_CONSTS_SVH
`define HMSB_OFS_CTRL 5'h00
`define HMSB_OFS_DECODE 5'h04
`define HMSB_OFS_GAP 5'h08
`define HMSB_OFS_STAT_A 5'h0C
`define HMSB_OFS_STAT_B 5'h10
`define HMSB_OFS_LINK 5'h14
`define HMSB_CTRL_FILT_BIT 0
`define HMSB_CTRL_ADDR_LSB 8
`define HMSB_LINK_BUSY_BIT 8
`define HMSB_LINK_FRAMES_LSB 16
`define HMSB_RST_FILT 1'h1
`define HMSB_RST_ADDR 6'h00
`define HMSB_RST_DECODE 8'hFF
`define HMSB_RST_GAP 8'h00
`define HMSB_RST_STAT 48'h000000000000
`define HMSB_LINK_MHZ 20
`define HMSB_MGMT_RX_CLOCK_MHZ 10
`define HMSB_HALF_BIT_CYC (`HMSB_LINK_MHZ / (2 * `HMSB_MGMT_RX_CLOCK_MHZ))
`define HMSB_SFD 8'hD5
`define HMSB_STAT_BITS 6'h37
`define HMSB_GAP_MAX 9'h1FF
`endif

// File: hdl/hmsb_pkg.sv
// Types shared by the hub management status bus transmitter
package hmsb_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_GAPHOLD, ST_FILL, ST_RUN, ST_DRAIN, ST_HOLD, ST_PAD, ST_STAT, ST_DONE
  } hmsb_state_e;
  typedef struct packed {
    logic filt;
    logic [5:0] chip_addr;
    logic [7:0] decode;
    logic [7:0] gap;
    logic [47:0] stat;
  } hmsb_cfg_s;
  typedef struct packed {
    logic [7:0] psr0;
    logic busy;
    logic [15:0] frames;
  } hmsb_stat_s;
endpackage : hmsb_pkg

// File: hdl/hmsb_word_if.sv
// Carrier for a word handed from one clock domain to another
`timescale 1ns/10ps
interface hmsb_word_if #(parameter int W = 8);
  logic [W-1:0] src_word;
  logic [W-1:0] dst_word;
  logic dst_upd;
  modport src (output src_word);
  modport xfer (input src_word, output dst_word, output dst_upd);
  modport dst (input dst_word, input dst_upd);
endinterface : hmsb_word_if

// File: hdl/hmsb_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module hmsb_sync3 #(parameter logic INIT = 1'b0) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Level in and filtered level out
  input wire logic din,
  output logic dout
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic out_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      out_q <= INIT;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) out_q <= s3_q;
    end
  end
  assign dout = out_q;
endmodule : hmsb_sync3

// File: hdl/hmsb_word_xfer.sv
// Toggle handshake that carries a word across clock domains
`timescale 1ns/10ps
module hmsb_word_xfer #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_WORD = '0
) (
  // Source domain
  input wire logic src_clk,
  input wire logic src_rst_n,
  // Destination domain
  input wire logic dst_clk,
  input wire logic dst_rst_n,
  // Word carrier
  hmsb_word_if.xfer bus
);
  logic [W-1:0] hold_q;
  logic req_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic req_s1_q;
  logic req_s2_q;
  logic req_s3_q;
  logic [W-1:0] word_q;
  logic upd_q;
  wire logic idle = req_q == ack_s2_q;
  wire logic fresh = req_s2_q != req_s3_q;
  // Hold is only reloaded once the far side has captured it
  always_ff @(posedge src_clk or negedge src_rst_n) begin
    if (!src_rst_n) begin
      hold_q <= RST_WORD;
      req_q <= 1'b0;
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= req_s3_q;
      ack_s2_q <= ack_s1_q;
      if (idle) hold_q <= bus.src_word;
      if (idle) req_q <= ~req_q;
    end
  end
  always_ff @(posedge dst_clk or negedge dst_rst_n) begin
    if (!dst_rst_n) begin
      req_s1_q <= 1'b0;
      req_s2_q <= 1'b0;
      req_s3_q <= 1'b0;
      word_q <= RST_WORD;
      upd_q <= 1'b0;
    end else begin
      req_s1_q <= req_q;
      req_s2_q <= req_s1_q;
      req_s3_q <= req_s2_q;
      upd_q <= fresh;
      if (fresh) word_q <= hold_q;
    end
  end
  assign bus.dst_word = word_q;
  assign bus.dst_upd = upd_q;
endmodule : hmsb_word_xfer

// File: hdl/hmsb_top.sv
// Hub management status bus transmitter with Avalon-MM registers
//
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/10ps
`include "hmsb_consts.svh"
module hmsb_top #(
  parameter int HALF_BIT_CYC = `HMSB_HALF_BIT_CYC
) (
  // System clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // Avalon-MM register slave
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Link clock
  input wire logic LINK_CLK,
  // Inter-repeater receive stream, link clock domain
  input wire logic INTER_REPEATER_RX_ACTIVE,
  input wire logic INTER_REPEATER_RX_DATA,
  // Truncate request pin
  input wire logic PACKET_TRUNCATE_REQUEST_N,
  // Management bus
  output logic MGMT_RX_CLOCK_O,
  output logic MGMT_RX_CLOCK_OE_N,
  output logic MGMT_RX_SERIAL_DATA_O,
  output logic MGMT_RX_SERIAL_DATA_OE_N,
  input wire logic MGMT_CARRIER_SENSE_N_I,
  output logic MGMT_CARRIER_SENSE_N_O,
  output logic MGMT_CARRIER_SENSE_N_OE_N
);
  import hmsb_pkg::*;

  localparam int CFG_W = $bits(hmsb_cfg_s);
  localparam int STA_W = $bits(hmsb_stat_s);
  localparam hmsb_cfg_s CFG_RST = '{filt: `HMSB_RST_FILT, chip_addr: `HMSB_RST_ADDR,
    decode: `HMSB_RST_DECODE, gap: `HMSB_RST_GAP, stat: `HMSB_RST_STAT};

  function automatic logic [31:0] be_merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                           input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      be_merge[8*i +: 8] = be[i] ? new_w[8*i +: 8] : old_w[8*i +: 8];
    end
  endfunction : be_merge

  // Register side
  logic filt_q;
  logic [5:0] addr_q;
  logic [7:0] decode_q;
  logic [7:0] gapthr_q;
  logic [47:0] stat_q;
  logic ack_q;
  logic [31:0] rdata_q;
  hmsb_stat_s link_stat;

  hmsb_word_if #(.W(CFG_W)) cfg_if ();
  hmsb_word_if #(.W(STA_W)) sta_if ();

  wire logic acc = AVS_READ | AVS_WRITE;
  wire logic wr_go = AVS_WRITE & ack_q;
  wire logic sel_ctrl = AVS_ADDRESS == `HMSB_OFS_CTRL;
  wire logic sel_dec = AVS_ADDRESS == `HMSB_OFS_DECODE;
  wire logic sel_gap = AVS_ADDRESS == `HMSB_OFS_GAP;
  wire logic sel_sta = AVS_ADDRESS == `HMSB_OFS_STAT_A;
  wire logic sel_stb = AVS_ADDRESS == `HMSB_OFS_STAT_B;
  wire logic sel_lnk = AVS_ADDRESS == `HMSB_OFS_LINK;
  wire logic [31:0] ctrl_word = (32'(addr_q) << `HMSB_CTRL_ADDR_LSB) | 32'(filt_q);
  wire logic [31:0] dec_word = {24'h000000, decode_q};
  wire logic [31:0] gap_word = {24'h000000, gapthr_q};
  wire logic [31:0] sta_word = stat_q[31:0];
  wire logic [31:0] stb_word = {16'h0000, stat_q[47:32]};
  wire logic [31:0] lnk_word = (32'(link_stat.frames) << `HMSB_LINK_FRAMES_LSB)
                             | (32'(link_stat.busy) << `HMSB_LINK_BUSY_BIT)
                             | 32'(link_stat.psr0);
  wire logic [31:0] rd_mux = sel_ctrl ? ctrl_word :
                             sel_dec ? dec_word :
                             sel_gap ? gap_word :
                             sel_sta ? sta_word :
                             sel_stb ? stb_word :
                             sel_lnk ? lnk_word : 32'h00000000;
  wire logic [31:0] ctrl_new = be_merge(ctrl_word, AVS_WRITEDATA, AVS_BYTEENABLE);
  wire logic [31:0] dec_new = be_merge(dec_word, AVS_WRITEDATA, AVS_BYTEENABLE);
  wire logic [31:0] gap_new = be_merge(gap_word, AVS_WRITEDATA, AVS_BYTEENABLE);
  wire logic [31:0] sta_new = be_merge(sta_word, AVS_WRITEDATA, AVS_BYTEENABLE);
  wire logic [31:0] stb_new = be_merge(stb_word, AVS_WRITEDATA, AVS_BYTEENABLE);

  // Every access takes exactly one wait cycle
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= acc & ~ack_q;
      if (AVS_READ & ~ack_q) rdata_q <= rd_mux;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      filt_q <= `HMSB_RST_FILT;
      addr_q <= `HMSB_RST_ADDR;
      decode_q <= `HMSB_RST_DECODE;
      gapthr_q <= `HMSB_RST_GAP;
      stat_q <= `HMSB_RST_STAT;
    end else if (wr_go) begin
      if (sel_ctrl) filt_q <= ctrl_new[`HMSB_CTRL_FILT_BIT];
      if (sel_ctrl) addr_q <= ctrl_new[`HMSB_CTRL_ADDR_LSB +: 6];
      if (sel_dec) decode_q <= dec_new[7:0];
      if (sel_gap) gapthr_q <= gap_new[7:0];
      if (sel_sta) stat_q[31:0] <= sta_new;
      if (sel_stb) stat_q[47:32] <= stb_new[15:0];
    end
  end

  assign AVS_WAITREQUEST = acc & ~ack_q;
  assign AVS_READDATA = rdata_q;
  assign cfg_if.src_word = {filt_q, addr_q, decode_q, gapthr_q, stat_q};
  assign link_stat = hmsb_stat_s'(sta_if.dst_word);

  // Link domain reset: asserted at once, released on the link clock
  logic lrst1_q;
  logic lrst2_q;
  always_ff @(posedge LINK_CLK or negedge RSTN) begin
    if (!RSTN) begin
      lrst1_q <= 1'b0;
      lrst2_q <= 1'b0;
    end else begin
      lrst1_q <= 1'b1;
      lrst2_q <= lrst1_q;
    end
  end
  wire logic link_rst_n = lrst2_q;

  hmsb_word_xfer #(.W(CFG_W), .RST_WORD(CFG_RST)) u_cfg_xfer (
    .src_clk(CLK),
    .src_rst_n(RSTN),
    .dst_clk(LINK_CLK),
    .dst_rst_n(link_rst_n),
    .bus(cfg_if)
  );
  hmsb_word_xfer #(.W(STA_W)) u_sta_xfer (
    .src_clk(LINK_CLK),
    .src_rst_n(link_rst_n),
    .dst_clk(CLK),
    .dst_rst_n(RSTN),
    .bus(sta_if)
  );

  logic trunc_n_s;
  logic crs_n_s;
  hmsb_sync3 #(.INIT(1'b1)) u_sync_trunc (
    .clk(LINK_CLK),
    .rst_n(link_rst_n),
    .din(PACKET_TRUNCATE_REQUEST_N),
    .dout(trunc_n_s)
  );
  hmsb_sync3 #(.INIT(1'b1)) u_sync_crs (
    .clk(LINK_CLK),
    .rst_n(link_rst_n),
    .din(MGMT_CARRIER_SENSE_N_I),
    .dout(crs_n_s)
  );

  // Link side
  hmsb_cfg_s cfg;
  hmsb_state_e st_q, st_d;
  logic [7:0] hb_q;
  logic ph_q;
  logic mgmt_rx_clock_q;
  logic [7:0] sr_q, sr_d;
  logic [3:0] fill_q, fill_d;
  logic [3:0] lead_q, lead_d;
  logic sfd_q, sfd_d;
  logic [15:0] post_q, post_d;
  logic [2:0] tot_q, tot_d;
  logic armed_q, armed_d;
  logic late_q, late_d;
  logic done_q, done_d;
  logic [55:0] ssr_q, ssr_d;
  logic [5:0] scnt_q, scnt_d;
  logic [8:0] gapc_q, gapc_d;
  logic crs_q, crs_d;
  logic [15:0] frames_q, frames_d;
  logic [7:0] plast_q, plast_d;
  logic dout_q;
  logic oval_q;
  logic emit;
  logic ebit;

  assign cfg = hmsb_cfg_s'(cfg_if.dst_word);
  wire logic act = INTER_REPEATER_RX_ACTIVE;
  wire logic ph_tick = hb_q == 8'(HALF_BIT_CYC - 1);
  wire logic bit_tick = ph_tick & ph_q;
  wire logic trunc = ~trunc_n_s;
  wire logic bus_busy = ~crs_n_s & ~crs_q;
  wire logic [7:0] sr_in = {INTER_REPEATER_RX_DATA, sr_q[7:1]};
  wire logic sfd_hit = ~sfd_q & (sr_in == `HMSB_SFD);
  wire logic [12:0] post_bytes = post_q[15:3];
  wire logic at_decode = sfd_q & (lead_q == 4'h0) & (post_q[2:0] == 3'h0)
                       & (post_bytes == 13'(cfg.decode));
  wire logic stop_now = armed_q & at_decode;
  wire logic arm_ok = post_bytes < 13'(cfg.decode);
  wire logic [2:0] align = sfd_q ? post_q[2:0] : tot_q;
  wire logic gap_short = gapc_q <= 9'(cfg.gap);
  wire logic [7:0] psr0 = {cfg.chip_addr, done_q, 1'b0};
  wire logic in_frame = (st_q == ST_FILL) | (st_q == ST_RUN) | (st_q == ST_DRAIN);

  always_comb begin
    st_d = st_q;
    sr_d = sr_q;
    fill_d = fill_q;
    lead_d = lead_q;
    sfd_d = sfd_q;
    post_d = post_q;
    tot_d = tot_q;
    armed_d = armed_q;
    late_d = late_q;
    done_d = done_q;
    ssr_d = ssr_q;
    scnt_d = scnt_q;
    gapc_d = gapc_q;
    crs_d = crs_q;
    frames_d = frames_q;
    plast_d = plast_q;
    emit = 1'b0;
    ebit = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (bus_busy) gapc_d = 9'h000;
        else if (gapc_q != `HMSB_GAP_MAX) gapc_d = gapc_q + 9'h001;
        if (act) begin
          sr_d = {INTER_REPEATER_RX_DATA, 7'h00};
          fill_d = 4'h1;
          lead_d = 4'h0;
          sfd_d = 1'b0;
          post_d = 16'h0000;
          tot_d = 3'h0;
          armed_d = 1'b0;
          late_d = 1'b0;
          done_d = 1'b0;
          st_d = gap_short ? ST_GAPHOLD : ST_FILL;
        end
      end
      ST_GAPHOLD: begin
        sr_d = sr_in;
        if (sfd_hit) sfd_d = 1'b1;
        crs_d = ~cfg.filt | sfd_q;
        if (!act) begin
          crs_d = 1'b0;
          gapc_d = 9'h000;
          st_d = ST_IDLE;
        end
      end
      ST_FILL: begin
        if (!act) begin
          sr_d = sr_q >> (4'h8 - fill_q);
          st_d = (cfg.filt & ~sfd_q) ? ST_IDLE : ST_DRAIN;
        end else begin
          sr_d = sr_in;
          fill_d = (fill_q == 4'h8) ? fill_q : fill_q + 4'h1;
          if (sfd_hit) sfd_d = 1'b1;
          if (sfd_hit) lead_d = 4'h8;
          if (fill_d == 4'h8 && (sfd_hit | ~cfg.filt)) begin
            st_d = ST_RUN;
            crs_d = 1'b1;
          end
        end
      end
      ST_RUN: begin
        if (stop_now) begin
          st_d = ST_HOLD;
          done_d = 1'b1;
        end else if (!act) begin
          st_d = ST_DRAIN;
        end else begin
          emit = 1'b1;
          ebit = sr_q[0];
          sr_d = sr_in;
          if (sfd_hit) sfd_d = 1'b1;
          if (sfd_hit) lead_d = 4'h8;
        end
      end
      ST_DRAIN: begin
        if (stop_now) begin
          st_d = ST_HOLD;
          done_d = 1'b1;
        end else begin
          emit = 1'b1;
          ebit = sr_q[0];
          sr_d = {1'b0, sr_q[7:1]};
          fill_d = fill_q - 4'h1;
          if (fill_q == 4'h1) st_d = ST_PAD;
        end
      end
      ST_HOLD: begin
        if (!act) st_d = ST_PAD;
      end
      ST_PAD: begin
        if (align == 3'h0) begin
          ssr_d = {cfg.stat, psr0};
          plast_d = psr0;
          scnt_d = 6'h00;
          st_d = ST_STAT;
        end else begin
          emit = 1'b1;
        end
      end
      ST_STAT: begin
        emit = 1'b1;
        ebit = ssr_q[0];
        ssr_d = {1'b0, ssr_q[55:1]};
        scnt_d = scnt_q + 6'h01;
        if (scnt_q == `HMSB_STAT_BITS) st_d = ST_DONE;
      end
      ST_DONE: begin
        crs_d = 1'b0;
        gapc_d = 9'h000;
        frames_d = frames_q + 16'h0001;
        st_d = ST_IDLE;
      end
      default: begin
        st_d = ST_IDLE;
        crs_d = 1'b0;
      end
    endcase
    if (emit) begin
      crs_d = 1'b1;
      tot_d = tot_q + 3'h1;
      if (lead_q != 4'h0) lead_d = lead_q - 4'h1;
      else if (sfd_q) post_d = post_q + 16'h0001;
    end
    if (in_frame & trunc & ~armed_q & ~late_q) begin
      if (arm_ok) armed_d = 1'b1;
      else late_d = 1'b1;
    end
  end

  // Bit timing and management clock
  always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      hb_q <= 8'h00;
      ph_q <= 1'b0;
      mgmt_rx_clock_q <= 1'b0;
    end else begin
      hb_q <= ph_tick ? 8'h00 : hb_q + 8'h01;
      if (ph_tick) ph_q <= ~ph_q;
      if (bit_tick) mgmt_rx_clock_q <= 1'b0;
      else if (ph_tick) mgmt_rx_clock_q <= oval_q;
    end
  end

  always_ff @(posedge LINK_CLK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      st_q <= ST_IDLE;
      sr_q <= 8'h00;
      fill_q <= 4'h0;
      lead_q <= 4'h0;
      sfd_q <= 1'b0;
      post_q <= 16'h0000;
      tot_q <= 3'h0;
      armed_q <= 1'b0;
      late_q <= 1'b0;
      done_q <= 1'b0;
      ssr_q <= 56'h00000000000000;
      scnt_q <= 6'h00;
      gapc_q <= `HMSB_GAP_MAX;
      crs_q <= 1'b0;
      frames_q <= 16'h0000;
      plast_q <= 8'h00;
      dout_q <= 1'b0;
      oval_q <= 1'b0;
    end else if (bit_tick) begin
      st_q <= st_d;
      sr_q <= sr_d;
      fill_q <= fill_d;
      lead_q <= lead_d;
      sfd_q <= sfd_d;
      post_q <= post_d;
      tot_q <= tot_d;
      armed_q <= armed_d;
      late_q <= late_d;
      done_q <= done_d;
      ssr_q <= ssr_d;
      scnt_q <= scnt_d;
      gapc_q <= gapc_d;
      crs_q <= crs_d;
      frames_q <= frames_d;
      plast_q <= plast_d;
      dout_q <= ebit;
      oval_q <= emit;
    end
  end

  assign sta_if.src_word = {plast_q, st_q != ST_IDLE, frames_q};
  // Bus lines are driven only while this chip owns the frame
  assign MGMT_RX_CLOCK_O = mgmt_rx_clock_q;
  assign MGMT_RX_SERIAL_DATA_O = dout_q;
  assign MGMT_CARRIER_SENSE_N_O = ~crs_q;
  assign MGMT_RX_CLOCK_OE_N = ~crs_q;
  assign MGMT_RX_SERIAL_DATA_OE_N = ~crs_q;
  assign MGMT_CARRIER_SENSE_N_OE_N = ~crs_q;
endmodule : hmsb_top

// File: tb/hmsb_top_assertions.sv
// Concurrent checks on the register handshake and the management bus
`timescale 1ns/10ps
module hmsb_top_assertions #(
  parameter int HALF_BIT_CYC = 1
) (
  // Clocks and reset
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic LINK_CLK,
  // Register handshake
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  // Link activity and management bus
  input wire logic INTER_REPEATER_RX_ACTIVE,
  input wire logic MGMT_RX_CLOCK_O,
  input wire logic MGMT_RX_CLOCK_OE_N,
  input wire logic MGMT_RX_SERIAL_DATA_O,
  input wire logic MGMT_RX_SERIAL_DATA_OE_N,
  input wire logic MGMT_CARRIER_SENSE_N_O,
  input wire logic MGMT_CARRIER_SENSE_N_OE_N
);
  logic [7:0] hi_cnt_q;
  logic [7:0] hi_cnt_d;

  // Counts how long the management clock has already stood high
  assign hi_cnt_d = MGMT_RX_CLOCK_O ? hi_cnt_q + 8'h01 : 8'h00;
  always_ff @(posedge LINK_CLK or negedge RSTN) begin
    if (!RSTN) begin
      hi_cnt_q <= 8'h00;
    end else begin
      hi_cnt_q <= hi_cnt_d;
    end
  end

  property p_oe_same;
    @(posedge LINK_CLK) disable iff (!RSTN)
    (MGMT_RX_CLOCK_OE_N == MGMT_CARRIER_SENSE_N_OE_N) &&
    (MGMT_RX_SERIAL_DATA_OE_N == MGMT_CARRIER_SENSE_N_OE_N);
  endproperty
  a_oe_same: assert property (p_oe_same) else $error("bus enables disagree");
  property p_crs_level;
    @(posedge LINK_CLK) disable iff (!RSTN) MGMT_CARRIER_SENSE_N_O == MGMT_CARRIER_SENSE_N_OE_N;
  endproperty
  a_crs_level: assert property (p_crs_level) else $error("carrier level wrong");
  property p_clk_owned;
    @(posedge LINK_CLK) disable iff (!RSTN) MGMT_RX_CLOCK_O |-> !MGMT_RX_CLOCK_OE_N;
  endproperty
  a_clk_owned: assert property (p_clk_owned) else $error("clock high while released");
  property p_data_at_rise;
    @(posedge LINK_CLK) disable iff (!RSTN)
    $rose(MGMT_RX_CLOCK_O) |-> $stable(MGMT_RX_SERIAL_DATA_O);
  endproperty
  a_data_at_rise: assert property (p_data_at_rise) else $error("data moved at clock rise");
  property p_clk_high;
    @(posedge LINK_CLK) disable iff (!RSTN) MGMT_RX_CLOCK_O |-> hi_cnt_q < HALF_BIT_CYC;
  endproperty
  a_clk_high: assert property (p_clk_high) else $error("clock high too long");
  property p_crs_in_frame;
    @(posedge LINK_CLK) disable iff (!RSTN)
    $fell(MGMT_CARRIER_SENSE_N_OE_N) |-> $past(INTER_REPEATER_RX_ACTIVE);
  endproperty
  a_crs_in_frame: assert property (p_crs_in_frame) else $error("carrier without activity");
  property p_crs_release;
    @(posedge LINK_CLK) disable iff (!RSTN)
    $rose(MGMT_CARRIER_SENSE_N_OE_N) |-> !MGMT_RX_CLOCK_O && !$past(MGMT_RX_CLOCK_O, 2);
  endproperty
  a_crs_release: assert property (p_crs_release) else $error("carrier dropped mid bit");
  property p_wait_once;
    @(posedge CLK) disable iff (!RSTN)
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST;
  endproperty
  a_wait_once: assert property (p_wait_once) else $error("more than one wait cycle");
  property p_wait_first;
    @(posedge CLK) disable iff (!RSTN) $rose(AVS_READ) || $rose(AVS_WRITE) |-> AVS_WAITREQUEST;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait on first cycle");

  c_frame: cover property (@(posedge LINK_CLK) disable iff (!RSTN) $fell(MGMT_CARRIER_SENSE_N_OE_N));
  c_hold: cover property (@(posedge LINK_CLK) disable iff (!RSTN)
    !MGMT_CARRIER_SENSE_N_OE_N && !MGMT_RX_CLOCK_O [*8]);
  c_read: cover property (@(posedge CLK) disable iff (!RSTN) AVS_READ && !AVS_WAITREQUEST);
endmodule : hmsb_top_assertions

bind hmsb_top hmsb_top_assertions #(.HALF_BIT_CYC(HALF_BIT_CYC)) hmsb_top_assertions_inst (
  .CLK, .RSTN, .LINK_CLK, .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST, .INTER_REPEATER_RX_ACTIVE,
  .MGMT_RX_CLOCK_O, .MGMT_RX_CLOCK_OE_N, .MGMT_RX_SERIAL_DATA_O, .MGMT_RX_SERIAL_DATA_OE_N,
  .MGMT_CARRIER_SENSE_N_O, .MGMT_CARRIER_SENSE_N_OE_N);

// File: tb/hmsb_ctl_model.sv
// Receiving network controller on the management bus
`timescale 1ns/10ps
module hmsb_ctl_model (
  // Backplane management lines
  input wire logic mclk,
  input wire logic mdat,
  input wire logic crs_n,
  // Received bytes of the current frame, and the count of closed frames
  output logic [7:0] rx_mem [64],
  output logic [7:0] rx_len,
  output logic [7:0] n_frames
);
  logic [7:0] sh;
  logic [2:0] nb;

  initial begin
    rx_len = 8'h00;
    n_frames = 8'h00;
    nb = 3'h0;
    sh = 8'h00;
  end
  // A carrier going low opens a frame, going high closes it
  always @(negedge crs_n) begin
    rx_len <= 8'h00;
    nb <= 3'h0;
  end
  always @(posedge crs_n) begin
    n_frames <= n_frames + 8'h01;
  end
  // Bits are taken on the rising clock, first bit into the byte's bit 0
  always @(posedge mclk) begin
    if (!crs_n) begin
      sh = {mdat, sh[7:1]};
      nb <= nb + 3'h1;
      if (nb == 3'h7 && rx_len < 8'h40) begin
        rx_mem[rx_len[5:0]] <= sh;
        rx_len <= rx_len + 8'h01;
      end
    end
  end
endmodule : hmsb_ctl_model

// File: tb/tb_top.sv
// Self-checking bench for the management bus transmitter
`timescale 1ns/10ps
module tb_top;
  localparam logic [5:0] ADDR = 6'h2D;
  logic clk, rst_n, link_clk;
  logic [4:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic rx_act, rx_dat, trunc_n;
  logic mclk_o, mclk_oe_n, mdat_o, mdat_oe_n, crs_n_o, crs_oe_n;
  logic mclk_w, mdat_w, crs_w;
  logic [7:0] rx_mem [64];
  logic [7:0] rx_len, n_frames, f;
  logic [7:0] exp_q [$];
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;

  // Backplane: clock pulled low, data and carrier pulled high
  assign mclk_w = mclk_oe_n ? 1'b0 : mclk_o;
  assign mdat_w = mdat_oe_n ? 1'b1 : mdat_o;
  assign crs_w = crs_oe_n ? 1'b1 : crs_n_o;

  hmsb_top #(.HALF_BIT_CYC(1)) hmsb_top_inst (.CLK(clk), .RSTN(rst_n),
    .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .LINK_CLK(link_clk),
    .INTER_REPEATER_RX_ACTIVE(rx_act), .INTER_REPEATER_RX_DATA(rx_dat),
    .PACKET_TRUNCATE_REQUEST_N(trunc_n), .MGMT_RX_CLOCK_O(mclk_o),
    .MGMT_RX_CLOCK_OE_N(mclk_oe_n), .MGMT_RX_SERIAL_DATA_O(mdat_o),
    .MGMT_RX_SERIAL_DATA_OE_N(mdat_oe_n), .MGMT_CARRIER_SENSE_N_I(crs_w),
    .MGMT_CARRIER_SENSE_N_O(crs_n_o), .MGMT_CARRIER_SENSE_N_OE_N(crs_oe_n));
  hmsb_ctl_model hmsb_ctl_model_inst (.mclk(mclk_w), .mdat(mdat_w), .crs_n(crs_w),
    .rx_mem(rx_mem), .rx_len(rx_len), .n_frames(n_frames));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever #6 link_clk = ~link_clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One register access, held until waitrequest is seen low
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      $display("ERROR %0t register access hung", $time);
    end
  endtask : acc

  task automatic rchk(input logic [4:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0, rd);
    chk(rd, exp);
  endtask : rchk

  // Write, then let the setting reach the link side
  task automatic cfg(input logic [4:0] a, input logic [31:0] d);
    acc(1'b1, a, d, rd);
    repeat (20) @(posedge clk);
  endtask : cfg

  // One bit per bit time: each value stands two link cycles
  task automatic lbit(input logic b);
    @(posedge link_clk);
    rx_act <= 1'b1;
    rx_dat <= b;
    @(posedge link_clk);
  endtask : lbit

  task automatic lbyte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      lbit(v[i]);
    end
  endtask : lbyte

  task automatic frame(input bit sfd, input int nb, input int tail, input int req_at);
    f = n_frames;
    lbyte(8'h55);
    lbyte(sfd ? 8'hD5 : 8'h55);
    for (int i = 0; i < nb; i++) begin
      if (i == req_at) begin
        trunc_n <= 1'b0;
      end
      lbyte(8'hA0 + 8'(i));
    end
    for (int i = 0; i < tail; i++) begin
      lbit(1'b1);
    end
    @(posedge link_clk);
    rx_act <= 1'b0;
    rx_dat <= 1'b0;
  endtask : frame

  // Waits for the carrier to be released by the transmitter
  task automatic wait_fr();
    int n;
    n = 0;
    while (n_frames === f && n < 5000) begin
      @(posedge link_clk);
      n++;
    end
    trunc_n <= 1'b1;
    chk({24'h0, n_frames}, {24'h0, f + 8'h01});
  endtask : wait_fr

  task automatic check_rx(input int nb, input logic [7:0] tb, input bit has_tail, input logic fl);
    exp_q = {8'hD5};
    for (int i = 0; i < nb; i++) begin
      exp_q.push_back(8'hA0 + 8'(i));
    end
    if (has_tail) begin
      exp_q.push_back(tb);
    end
    exp_q.push_back({ADDR, fl, 1'b0});
    for (int i = 1; i < 7; i++) begin
      exp_q.push_back(8'h11 * 8'(i));
    end
    chk({24'h0, rx_len}, 32'(exp_q.size()));
    foreach (exp_q[i]) begin
      chk({24'h0, rx_mem[i]}, {24'h0, exp_q[i]});
    end
  endtask : check_rx

  initial begin
    rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    rx_act = 1'b0;
    rx_dat = 1'b0;
    trunc_n = 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rchk(5'h00, 32'h00000001);
    rchk(5'h04, 32'h000000FF);
    rchk(5'h08, 32'h00000000);
    rchk(5'h0C, 32'h00000000);
    rchk(5'h10, 32'h00000000);
    acc(1'b1, 5'h1C, 32'hFFFFFFFF, rd);
    rchk(5'h1C, 32'h00000000);
    acc(1'b1, 5'h0C, 32'h44330011, rd);
    avs_byteenable <= 4'h2;
    acc(1'b1, 5'h0C, 32'hFFFF22FF, rd);
    avs_byteenable <= 4'hF;
    acc(1'b1, 5'h10, 32'h00006655, rd);
    cfg(5'h00, {18'h0, ADDR, 8'h01});
    frame(1, 4, 0, 99);
    wait_fr();
    check_rx(4, 8'h00, 0, 1'b0);
    repeat (20) @(posedge clk);
    frame(1, 2, 4, 99);
    wait_fr();
    check_rx(2, 8'h0F, 1, 1'b0);
    cfg(5'h04, 32'h00000002);
    frame(1, 6, 0, 0);
    wait_fr();
    check_rx(2, 8'h00, 0, 1'b1);
    acc(1'b0, 5'h14, 32'h0, rd);
    chk({24'h0, rd[7:0]}, {24'h0, ADDR, 2'b10});
    cfg(5'h04, 32'h00000001);
    frame(1, 4, 0, 3);
    wait_fr();
    check_rx(4, 8'h00, 0, 1'b0);
    repeat (20) @(posedge clk);
    frame(0, 4, 0, 99);
    repeat (300) @(posedge link_clk);
    chk({24'h0, n_frames}, {24'h0, f});
    cfg(5'h00, {18'h0, ADDR, 8'h00});
    frame(0, 4, 0, 99);
    wait_fr();
    chk({24'h0, rx_len}, 32'h0000000D);
    cfg(5'h00, {18'h0, ADDR, 8'h01});
    cfg(5'h08, 32'h000000C8);
    repeat (500) @(posedge clk);
    frame(1, 2, 0, 99);
    wait_fr();
    check_rx(2, 8'h00, 0, 1'b0);
    frame(1, 2, 0, 99);
    wait_fr();
    chk({24'h0, rx_len}, 32'h0);
    wrap_up();
  end
endmodule : tb_top
